// [hdl/bms_pkg.sv]
package bms_pkg;

   // ---------------------------------------------------------------
   // variants and codes
   // ---------------------------------------------------------------
   localparam logic [1:0] BMS_VAR_A = 2'h0;   // first 3-bit family
   localparam logic [1:0] BMS_VAR_B = 2'h1;   // second 3-bit family
   localparam logic [1:0] BMS_VAR_C = 2'h2;   // 4-bit family
   localparam logic [1:0] BMS_VAR_D = 2'h3;   // third 3-bit family

   localparam logic [31:0] BMS_ROM_ENTRY   = 32'hef00_0000;
   localparam logic [31:0] BMS_ADDR_ZERO   = 32'h0000_0000;
   localparam logic [31:0] BMS_ADDR_FLASH  = 32'h2000_0000;
   localparam logic [31:0] BMS_ADDR_INTSPI = 32'h2030_0000;
   localparam logic [31:0] BMS_ADDR_SDRAM  = 32'h0000_0010;
   localparam logic [31:0] BMS_OTP_PAGE    = 32'h0000_0040;
   localparam logic [31:0] BMS_ADDR_NONE   = 32'h0000_0000;

   localparam int unsigned BMS_NAND_BLOCK_BYTES = 256;
   localparam int unsigned BMS_NAND_PAD_BYTES   = 256;
   localparam int unsigned BMS_OTP_WIDTH        = 32;
   localparam logic [7:0]  BMS_OTP_HEX_SCALE    = 8'h10;

   localparam logic [3:0] BMS_MODE_RESET = 4'h0;
   localparam logic [4:0] BMS_SRC_RESET  = 5'h00;

   // ---------------------------------------------------------------
   // boot sources
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      BMS_SRC_IDLE       = 5'h00,
      BMS_SRC_FLASH_ASYN = 5'h01,
      BMS_SRC_FLASH_SYNC = 5'h02,
      BMS_SRC_SPI_MEM    = 5'h03,
      BMS_SRC_SPI_HOST   = 5'h04,
      BMS_SRC_PAR_HOST   = 5'h05,
      BMS_SRC_UART_HOST  = 5'h06,
      BMS_SRC_EXT_FLASH  = 5'h07,
      BMS_SRC_INT_SPI    = 5'h08,
      BMS_SRC_OTP        = 5'h09,
      BMS_SRC_SDRAM      = 5'h0a,
      BMS_SRC_FIFO       = 5'h0b,
      BMS_SRC_TWI_MEM    = 5'h0c,
      BMS_SRC_TWI_HOST   = 5'h0d,
      BMS_SRC_UART2_HOST = 5'h0e,
      BMS_SRC_NAND       = 5'h0f,
      BMS_SRC_HDMA16     = 5'h10,
      BMS_SRC_HDMA8      = 5'h11,
      BMS_SRC_SPI2_MEM   = 5'h12,
      BMS_SRC_SPI2_HOST  = 5'h13,
      BMS_SRC_INT_ROM    = 5'h14,
      BMS_SRC_RESERVED   = 5'h1f
   } bms_src_t;

   typedef enum logic [1:0] {
      BMS_ST_RESET = 2'b00,
      BMS_ST_CATCH = 2'b01,
      BMS_ST_HOLD  = 2'b11
   } bms_state_t;

   typedef struct packed {
      bms_src_t    src;
      logic [31:0] start_addr;
      logic        addr_valid;
      logic        master;
      logic        idle;
      logic        reserved;
      logic        nand_prefetch;
      logic        otp_word32;
   } bms_decode_t;

endpackage : bms_pkg

// [hdl/bms_boot_mode_selector.sv]
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - after reset fetch from boot rom entry
// - mode pins only select boot mode
// - pin state readable in system config register
// - first family: idle, spi, hosts, reserved, uart
// - first family flash codes start at flash
// - no internal flash drops codes 001, 010
// - second family flash, internal and external spi
// - second family hosts, otp, sdram, no address
// - 4-bit: idle, flash default, fifo
// - 4-bit 0011 spi memory at zero
// - 4-bit spi host, two-wire memory and host
// - 4-bit uart hosts and reserved codes
// - 4-bit sdram, otp page, nand codes
// - third family idle, reserved, second spi port
// - third family first spi, hosts, internal rom
// - master fetches, slave receives pushed data
// - nand fetches 256-byte blocks with prefetch
// - otp transfers always 32-bit words
module bms_boot_mode_selector
   import bms_pkg::*;
#(
   parameter logic [1:0] VARIANT       = BMS_VAR_C,
   parameter logic       HAS_INT_FLASH = 1'b1,
   parameter logic       HAS_UART2     = 1'b1
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // mode pins
   input  wire logic [3:0]  boot_mode_pins,
   // decoded boot selection
   output bms_decode_t      boot_sel,
   output logic [31:0]      boot_fetch_addr,
   output logic             boot_sel_valid,
   // system config register view of the pins
   output logic [3:0]       system_config_register
);

   // the code checks below sample on mclk and rest while reset is low
   default clocking bms_cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   function automatic bms_decode_t bms_entry(input bms_src_t s, input logic [31:0] a,
                                             input logic av, input logic m);
      bms_decode_t r;
      r.src           = s;
      r.start_addr    = a;
      r.addr_valid    = av;
      r.master        = m;
      r.idle          = (s == BMS_SRC_IDLE);
      r.reserved      = (s == BMS_SRC_RESERVED);
      r.nand_prefetch = (s == BMS_SRC_NAND);
      r.otp_word32    = (s == BMS_SRC_OTP);
      return r;
   endfunction

   function automatic bms_decode_t bms_decode(input logic [1:0] v, input logic [3:0] p);
      bms_decode_t r;
      r = bms_entry(BMS_SRC_RESERVED, BMS_ADDR_NONE, 1'b0, 1'b0);
      unique case (v)
         BMS_VAR_A: begin
            unique case (p[2:0])
               3'h0: r = bms_entry(BMS_SRC_IDLE, BMS_ADDR_NONE, 1'b0, 1'b0);
               3'h1: r = HAS_INT_FLASH ?
                         bms_entry(BMS_SRC_FLASH_ASYN, BMS_ADDR_FLASH, 1'b1, 1'b1) :
                         bms_entry(BMS_SRC_RESERVED, BMS_ADDR_NONE, 1'b0, 1'b0);
               3'h2: r = HAS_INT_FLASH ?
                         bms_entry(BMS_SRC_FLASH_SYNC, BMS_ADDR_FLASH, 1'b1, 1'b1) :
                         bms_entry(BMS_SRC_RESERVED, BMS_ADDR_NONE, 1'b0, 1'b0);
               3'h3: r = bms_entry(BMS_SRC_SPI_MEM, BMS_ADDR_ZERO, 1'b1, 1'b1);
               3'h4: r = bms_entry(BMS_SRC_SPI_HOST, BMS_ADDR_NONE, 1'b0, 1'b0);
               3'h5: r = bms_entry(BMS_SRC_PAR_HOST, BMS_ADDR_NONE, 1'b0, 1'b0);
               3'h6: r = bms_entry(BMS_SRC_RESERVED, BMS_ADDR_NONE, 1'b0, 1'b0);
               3'h7: r = bms_entry(BMS_SRC_UART_HOST, BMS_ADDR_NONE, 1'b0, 1'b0);
            endcase
         end
         BMS_VAR_B: begin
            unique case (p[2:0])
               3'h0: r = bms_entry(BMS_SRC_IDLE, BMS_ADDR_NONE, 1'b0, 1'b0);
               3'h1: r = bms_entry(BMS_SRC_EXT_FLASH, BMS_ADDR_FLASH, 1'b1, 1'b1);
               3'h2: r = bms_entry(BMS_SRC_INT_SPI, BMS_ADDR_INTSPI, 1'b1, 1'b1);
               3'h3: r = bms_entry(BMS_SRC_SPI_MEM, BMS_ADDR_ZERO, 1'b1, 1'b1);
               3'h4: r = bms_entry(BMS_SRC_SPI_HOST, BMS_ADDR_NONE, 1'b0, 1'b0);
               3'h5: r = bms_entry(BMS_SRC_OTP, BMS_ADDR_NONE, 1'b0, 1'b1);
               3'h6: r = bms_entry(BMS_SRC_SDRAM, BMS_ADDR_NONE, 1'b0, 1'b1);
               3'h7: r = bms_entry(BMS_SRC_UART_HOST, BMS_ADDR_NONE, 1'b0, 1'b0);
            endcase
         end
         BMS_VAR_C: begin
            unique case (p)
               4'h0: r = bms_entry(BMS_SRC_IDLE, BMS_ADDR_NONE, 1'b0, 1'b0);
               4'h1: r = bms_entry(BMS_SRC_EXT_FLASH, BMS_ADDR_FLASH, 1'b1, 1'b1);
               4'h2: r = bms_entry(BMS_SRC_FIFO, BMS_ADDR_INTSPI, 1'b1, 1'b0);
               4'h3: r = bms_entry(BMS_SRC_SPI_MEM, BMS_ADDR_ZERO, 1'b1, 1'b1);
               4'h4: r = bms_entry(BMS_SRC_SPI_HOST, BMS_ADDR_NONE, 1'b0, 1'b0);
               4'h5: r = bms_entry(BMS_SRC_TWI_MEM, BMS_ADDR_ZERO, 1'b1, 1'b1);
               4'h6: r = bms_entry(BMS_SRC_TWI_HOST, BMS_ADDR_NONE, 1'b0, 1'b0);
               4'h7: r = bms_entry(BMS_SRC_UART_HOST, BMS_ADDR_NONE, 1'b0, 1'b0);
               4'h8: r = HAS_UART2 ?
                         bms_entry(BMS_SRC_UART2_HOST, BMS_ADDR_NONE, 1'b0, 1'b0) :
                         bms_entry(BMS_SRC_RESERVED, BMS_ADDR_NONE, 1'b0, 1'b0);
               4'h9: r = bms_entry(BMS_SRC_RESERVED, BMS_ADDR_NONE, 1'b0, 1'b0);
               4'ha: r = bms_entry(BMS_SRC_SDRAM, BMS_ADDR_SDRAM, 1'b1, 1'b1);
               4'hb: r = bms_entry(BMS_SRC_OTP, BMS_OTP_PAGE, 1'b1, 1'b1);
               4'hc,
               4'hd: r = bms_entry(BMS_SRC_NAND, BMS_ADDR_ZERO, 1'b1, 1'b1);
               4'he: r = bms_entry(BMS_SRC_HDMA16, BMS_ADDR_NONE, 1'b0, 1'b0);
               4'hf: r = bms_entry(BMS_SRC_HDMA8, BMS_ADDR_NONE, 1'b0, 1'b0);
            endcase
         end
         BMS_VAR_D: begin
            unique case (p[2:0])
               3'h0: r = bms_entry(BMS_SRC_IDLE, BMS_ADDR_NONE, 1'b0, 1'b0);
               3'h1: r = bms_entry(BMS_SRC_RESERVED, BMS_ADDR_NONE, 1'b0, 1'b0);
               3'h2: r = bms_entry(BMS_SRC_SPI2_MEM, BMS_ADDR_NONE, 1'b0, 1'b1);
               3'h3: r = bms_entry(BMS_SRC_SPI2_HOST, BMS_ADDR_NONE, 1'b0, 1'b0);
               3'h4: r = bms_entry(BMS_SRC_SPI_MEM, BMS_ADDR_NONE, 1'b0, 1'b1);
               3'h5: r = bms_entry(BMS_SRC_PAR_HOST, BMS_ADDR_NONE, 1'b0, 1'b0);
               3'h6: r = bms_entry(BMS_SRC_UART_HOST, BMS_ADDR_NONE, 1'b0, 1'b0);
               3'h7: r = bms_entry(BMS_SRC_INT_ROM, BMS_ADDR_FLASH, 1'b1, 1'b1);
            endcase
         end
      endcase
      return r;
   endfunction

   // ---------------------------------------------------------------
   // capture sequence
   // ---------------------------------------------------------------
   // pins are caught on the first clock after release, never under the reset itself
   bms_state_t state_q;
   bms_state_t state_d;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         BMS_ST_RESET: state_d = BMS_ST_CATCH;
         BMS_ST_CATCH: state_d = BMS_ST_HOLD;
         BMS_ST_HOLD:  state_d = BMS_ST_HOLD;
         default:      state_d = BMS_ST_RESET;
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_q <= BMS_ST_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   logic [3:0] pins_q;

   // pins are not looked at once held: they steer nothing else
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pins_q <= BMS_MODE_RESET;
      end else if (state_q == BMS_ST_RESET) begin
         pins_q <= (VARIANT == BMS_VAR_C) ? boot_mode_pins : {1'b0, boot_mode_pins[2:0]};
      end
   end

   bms_decode_t sel_q;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sel_q <= bms_entry(BMS_SRC_IDLE, BMS_ADDR_NONE, 1'b0, 1'b0);
      end else if (state_q == BMS_ST_CATCH) begin
         sel_q <= bms_decode(VARIANT, pins_q);
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   logic valid_q;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         valid_q <= 1'b0;
      end else begin
         valid_q <= (state_q == BMS_ST_CATCH) | valid_q;
      end
   end

   assign boot_sel               = sel_q;
   assign boot_fetch_addr        = BMS_ROM_ENTRY;
   assign boot_sel_valid         = valid_q;
   assign system_config_register = pins_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence bms_release_s;
      state_q == BMS_ST_RESET ##1 state_q == BMS_ST_CATCH;
   endsequence

   rom_entry_a: assert property (@(posedge mclk) disable iff (!rstn)
      boot_fetch_addr == 32'hef00_0000)
      else $error("boot fetch address is not the rom entry");

   sel_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
      valid_q |=> $stable(sel_q) && $stable(pins_q))
      else $error("boot selection changed after capture");

   sel_valid_a: assert property (@(posedge mclk) disable iff (!rstn)
      bms_release_s |=> valid_q && sel_q == bms_decode(VARIANT, pins_q))
      else $error("selection not decoded after release");

   valid_early_a: assert property (bms_release_s |-> !valid_q)
      else $error("selection valid before the decode edge");

   cfg_view_a: assert property (@(posedge mclk) disable iff (!rstn)
      state_q == BMS_ST_CATCH |-> system_config_register == ((VARIANT == BMS_VAR_C) ?
         $past(boot_mode_pins) : {1'b0, $past(boot_mode_pins[2:0])}))
      else $error("config register does not show the pins");

   nand_flag_a: assert property (@(posedge mclk) disable iff (!rstn)
      valid_q && sel_q.src == BMS_SRC_NAND |-> sel_q.nand_prefetch && sel_q.master)
      else $error("nand boot lacks prefetch or master");

   otp_flag_a: assert property (@(posedge mclk) disable iff (!rstn)
      sel_q.otp_word32 == (sel_q.src == BMS_SRC_OTP))
      else $error("otp width flag wrong");

   host_slave_a: assert property (@(posedge mclk) disable iff (!rstn)
      valid_q && (sel_q.src == BMS_SRC_HDMA16 || sel_q.src == BMS_SRC_HDMA8) |->
         !sel_q.master && !sel_q.addr_valid)
      else $error("host dma marked as master");

   flash_gate_a: assert property (@(posedge mclk) disable iff (!rstn)
      valid_q && VARIANT == BMS_VAR_A && !HAS_INT_FLASH && pins_q[2:1] != 2'h3
         && pins_q[2:0] inside {3'h1, 3'h2} |-> sel_q.reserved)
      else $error("flash code accepted without internal flash");

   code_map_a: assert property (@(posedge mclk) disable iff (!rstn)
      valid_q && VARIANT == BMS_VAR_C && pins_q == 4'ha |->
         sel_q.src == BMS_SRC_SDRAM && sel_q.start_addr == 32'h0000_0010)
      else $error("sdram code decoded wrong");

   // one gate per family: codes are only judged once a selection is held
   logic on_var_a;
   logic on_var_b;
   logic on_var_c;
   logic on_var_d;

   assign on_var_a = valid_q && (VARIANT == BMS_VAR_A);
   assign on_var_b = valid_q && (VARIANT == BMS_VAR_B);
   assign on_var_c = valid_q && (VARIANT == BMS_VAR_C);
   assign on_var_d = valid_q && (VARIANT == BMS_VAR_D);

   a_idle_a: assert property (on_var_a && pins_q == 4'h0 |->
      sel_q.idle && !sel_q.master && !sel_q.addr_valid)
      else $error("first family idle code decoded wrong");

   a_spi_a: assert property (on_var_a && pins_q == 4'h3 |->
      sel_q.src == BMS_SRC_SPI_MEM && sel_q.start_addr == 32'h0000_0000 && sel_q.master)
      else $error("first family spi memory code decoded wrong");

   a_hosts_a: assert property (on_var_a && pins_q inside {4'h4, 4'h5, 4'h7} |->
      !sel_q.master && !sel_q.addr_valid && !sel_q.reserved)
      else $error("first family host code decoded wrong");

   a_flash_a: assert property (on_var_a && HAS_INT_FLASH && pins_q inside {4'h1, 4'h2} |->
      sel_q.start_addr == 32'h2000_0000 && sel_q.addr_valid && sel_q.master)
      else $error("first family flash code decoded wrong");

   b_flash_a: assert property (on_var_b && pins_q == 4'h1 |->
      sel_q.src == BMS_SRC_EXT_FLASH && sel_q.start_addr == 32'h2000_0000)
      else $error("second family flash code decoded wrong");

   b_int_spi_a: assert property (on_var_b && pins_q == 4'h2 |->
      sel_q.src == BMS_SRC_INT_SPI && sel_q.start_addr == 32'h2030_0000)
      else $error("second family internal spi code decoded wrong");

   b_ext_spi_a: assert property (on_var_b && pins_q == 4'h3 |->
      sel_q.src == BMS_SRC_SPI_MEM && sel_q.start_addr == 32'h0000_0000)
      else $error("second family external spi code decoded wrong");

   b_no_addr_a: assert property (on_var_b && pins_q[2] |->
      !sel_q.addr_valid && !sel_q.reserved)
      else $error("second family upper code has a start address");

   b_otp_a: assert property (on_var_b && pins_q == 4'h5 |->
      sel_q.src == BMS_SRC_OTP && sel_q.otp_word32)
      else $error("second family otp code decoded wrong");

   c_flash_a: assert property (on_var_c && pins_q == 4'h1 |->
      sel_q.src == BMS_SRC_EXT_FLASH && sel_q.start_addr == 32'h2000_0000)
      else $error("4-bit flash code decoded wrong");

   c_fifo_a: assert property (on_var_c && pins_q == 4'h2 |->
      sel_q.src == BMS_SRC_FIFO && sel_q.start_addr == 32'h2030_0000)
      else $error("4-bit fifo code decoded wrong");

   c_spi_mem_a: assert property (on_var_c && pins_q == 4'h3 |->
      sel_q.src == BMS_SRC_SPI_MEM && sel_q.start_addr == 32'h0000_0000 && sel_q.addr_valid)
      else $error("4-bit spi memory code decoded wrong");

   c_twi_mem_a: assert property (on_var_c && pins_q == 4'h5 |->
      sel_q.src == BMS_SRC_TWI_MEM && sel_q.start_addr == 32'h0000_0000 && sel_q.addr_valid)
      else $error("4-bit two-wire memory code decoded wrong");

   c_hosts_a: assert property (on_var_c && pins_q inside {4'h4, 4'h6} |->
      sel_q.src inside {BMS_SRC_SPI_HOST, BMS_SRC_TWI_HOST} && !sel_q.master)
      else $error("4-bit host code decoded wrong");

   c_uart2_a: assert property (on_var_c && pins_q == 4'h8 |->
      (sel_q.reserved != HAS_UART2) && !sel_q.master)
      else $error("4-bit second uart code decoded wrong");

   c_reserved_a: assert property (on_var_c && pins_q == 4'h9 |->
      sel_q.reserved && !sel_q.addr_valid)
      else $error("4-bit reserved code decoded wrong");

   c_otp_page_a: assert property (on_var_c && pins_q == 4'hb |->
      sel_q.src == BMS_SRC_OTP && sel_q.start_addr == 32'h0000_0040)
      else $error("4-bit otp code decoded wrong");

   c_nand_a: assert property (on_var_c && pins_q inside {4'hc, 4'hd} |->
      sel_q.src == BMS_SRC_NAND && sel_q.start_addr == 32'h0000_0000 && sel_q.addr_valid)
      else $error("4-bit nand code decoded wrong");

   c_hdma_a: assert property (on_var_c && pins_q[3:1] == 3'h7 |->
      sel_q.src == (pins_q[0] ? BMS_SRC_HDMA8 : BMS_SRC_HDMA16))
      else $error("4-bit host dma code decoded wrong");

   d_reserved_a: assert property (on_var_d && pins_q == 4'h1 |->
      sel_q.reserved && !sel_q.idle)
      else $error("third family reserved code decoded wrong");

   d_spi2_a: assert property (on_var_d && pins_q inside {4'h2, 4'h3} |->
      sel_q.src inside {BMS_SRC_SPI2_MEM, BMS_SRC_SPI2_HOST})
      else $error("third family second port code decoded wrong");

   d_first_spi_a: assert property (on_var_d && pins_q == 4'h4 |->
      sel_q.src == BMS_SRC_SPI_MEM && sel_q.master && !sel_q.addr_valid)
      else $error("third family first port code decoded wrong");

   d_rom_a: assert property (on_var_d && pins_q == 4'h7 |->
      sel_q.src == BMS_SRC_INT_ROM && sel_q.start_addr == 32'h2000_0000)
      else $error("third family rom code decoded wrong");

endmodule : bms_boot_mode_selector
`default_nettype wire

// [bench/bms_strap_model.sv]
`timescale 1ns/1ps
`default_nettype none
module bms_strap_model
   import bms_pkg::*;
#(
   parameter logic [15:0] HDMA_FIFO_DEPTH = 16'h0008   // host port fifo depth, power of two
) (
   // control
   input  wire logic        mclk,
   input  wire logic [3:0]  strap_code,
   input  wire logic        wiggle,
   input  wire logic [15:0] hdma_payload,
   // board side
   output logic [3:0]       boot_mode_pins,
   output logic [11:0]      otp_hex_offset,
   output logic [15:0]      hdma_block_len
);
   logic [3:0] toggle_q;

   // a careless board reuses the straps after capture: flip them every cycle
   always_ff @(posedge mclk) begin
      toggle_q <= wiggle ? ~boot_mode_pins : strap_code;
   end
   assign boot_mode_pins = wiggle ? toggle_q : strap_code;
   // hex image offset of the otp start page
   assign otp_hex_offset = {BMS_OTP_PAGE[7:0], 4'h0};
   // host dma stream: payload blocks padded up to whole fifo loads
   assign hdma_block_len = (hdma_payload + HDMA_FIFO_DEPTH - 16'h0001)
                         & ~(HDMA_FIFO_DEPTH - 16'h0001);
endmodule // bms_strap_model
`default_nettype wire

// [bench/tb_bms_boot_mode_selector.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_bms_boot_mode_selector
   import bms_pkg::*;
();
   // -------------------------------------------------------------
   // six configurations side by side on one strap bus
   // -------------------------------------------------------------
   localparam logic [1:0] CFG_VAR [6] = '{BMS_VAR_A, BMS_VAR_A, BMS_VAR_B,
                                          BMS_VAR_C, BMS_VAR_C, BMS_VAR_D};
   localparam logic [5:0] CFG_FL = 6'h3d;
   localparam logic [5:0] CFG_U2 = 6'h2f;
   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   logic [3:0]  strap_code = 4'h0;
   logic        wiggle = 1'b0;
   logic [3:0]  pins;
   logic [11:0] otp_off;
   logic [15:0] hdma_pay = 16'h0000;
   logic [15:0] hdma_len;
   bms_decode_t sel [6];
   logic [31:0] fa [6];
   logic        vld [6];
   logic [3:0]  scr [6];
   int          error_cnt = 0;
   int          checked = 0;

   always #2.5 mclk = ~mclk;

   bms_strap_model u_bms_strap_model (.mclk(mclk), .strap_code(strap_code), .wiggle(wiggle),
                                      .hdma_payload(hdma_pay), .boot_mode_pins(pins),
                                      .otp_hex_offset(otp_off), .hdma_block_len(hdma_len));
   for (genvar i = 0; i < 6; i++) begin : g_dut
      bms_boot_mode_selector #(.VARIANT(CFG_VAR[i]), .HAS_INT_FLASH(CFG_FL[i]),
                               .HAS_UART2(CFG_U2[i])) u_bms_boot_mode_selector (
         .mclk(mclk), .rstn(rstn), .boot_mode_pins(pins), .boot_sel(sel[i]),
         .boot_fetch_addr(fa[i]), .boot_sel_valid(vld[i]), .system_config_register(scr[i]));
   end

   // -------------------------------------------------------------
   // expectations
   // -------------------------------------------------------------
   function automatic bms_decode_t mk(bms_src_t s, logic [31:0] a, logic av, logic m);
      bms_decode_t e;
      e = '0;
      e.src = s;
      e.start_addr = a;
      e.addr_valid = av;
      e.master = m;
      e.idle = (s == BMS_SRC_IDLE);
      e.reserved = (s == BMS_SRC_RESERVED);
      e.nand_prefetch = (s == BMS_SRC_NAND);
      e.otp_word32 = (s == BMS_SRC_OTP);
      return e;
   endfunction

   function automatic bms_decode_t exp_dec(int i, logic [3:0] p);
      logic [1:0] v;
      logic [3:0] c;
      v = CFG_VAR[i];
      c = (v == BMS_VAR_C) ? p : {1'b0, p[2:0]};
      case ({v, c})
         {BMS_VAR_A, 4'h0}, {BMS_VAR_B, 4'h0}, {BMS_VAR_C, 4'h0}, {BMS_VAR_D, 4'h0}:
            return mk(BMS_SRC_IDLE, BMS_ADDR_NONE, 1'b0, 1'b0);
         {BMS_VAR_A, 4'h1}: if (CFG_FL[i])
            return mk(BMS_SRC_FLASH_ASYN, BMS_ADDR_FLASH, 1'b1, 1'b1);
         {BMS_VAR_A, 4'h2}: if (CFG_FL[i])
            return mk(BMS_SRC_FLASH_SYNC, BMS_ADDR_FLASH, 1'b1, 1'b1);
         {BMS_VAR_A, 4'h3}, {BMS_VAR_B, 4'h3}, {BMS_VAR_C, 4'h3}:
            return mk(BMS_SRC_SPI_MEM, BMS_ADDR_ZERO, 1'b1, 1'b1);
         {BMS_VAR_A, 4'h4}, {BMS_VAR_B, 4'h4}, {BMS_VAR_C, 4'h4}:
            return mk(BMS_SRC_SPI_HOST, BMS_ADDR_NONE, 1'b0, 1'b0);
         {BMS_VAR_A, 4'h5}, {BMS_VAR_D, 4'h5}:
            return mk(BMS_SRC_PAR_HOST, BMS_ADDR_NONE, 1'b0, 1'b0);
         {BMS_VAR_A, 4'h7}, {BMS_VAR_B, 4'h7}, {BMS_VAR_C, 4'h7}, {BMS_VAR_D, 4'h6}:
            return mk(BMS_SRC_UART_HOST, BMS_ADDR_NONE, 1'b0, 1'b0);
         {BMS_VAR_B, 4'h1}, {BMS_VAR_C, 4'h1}:
            return mk(BMS_SRC_EXT_FLASH, BMS_ADDR_FLASH, 1'b1, 1'b1);
         {BMS_VAR_B, 4'h2}: return mk(BMS_SRC_INT_SPI, BMS_ADDR_INTSPI, 1'b1, 1'b1);
         {BMS_VAR_B, 4'h5}: return mk(BMS_SRC_OTP, BMS_ADDR_NONE, 1'b0, 1'b1);
         {BMS_VAR_B, 4'h6}: return mk(BMS_SRC_SDRAM, BMS_ADDR_NONE, 1'b0, 1'b1);
         {BMS_VAR_C, 4'h2}: return mk(BMS_SRC_FIFO, BMS_ADDR_INTSPI, 1'b1, 1'b0);
         {BMS_VAR_C, 4'h5}: return mk(BMS_SRC_TWI_MEM, BMS_ADDR_ZERO, 1'b1, 1'b1);
         {BMS_VAR_C, 4'h6}: return mk(BMS_SRC_TWI_HOST, BMS_ADDR_NONE, 1'b0, 1'b0);
         {BMS_VAR_C, 4'h8}: if (CFG_U2[i])
            return mk(BMS_SRC_UART2_HOST, BMS_ADDR_NONE, 1'b0, 1'b0);
         {BMS_VAR_C, 4'ha}: return mk(BMS_SRC_SDRAM, BMS_ADDR_SDRAM, 1'b1, 1'b1);
         {BMS_VAR_C, 4'hb}: return mk(BMS_SRC_OTP, BMS_OTP_PAGE, 1'b1, 1'b1);
         {BMS_VAR_C, 4'hc}, {BMS_VAR_C, 4'hd}:
            return mk(BMS_SRC_NAND, BMS_ADDR_ZERO, 1'b1, 1'b1);
         {BMS_VAR_C, 4'he}: return mk(BMS_SRC_HDMA16, BMS_ADDR_NONE, 1'b0, 1'b0);
         {BMS_VAR_C, 4'hf}: return mk(BMS_SRC_HDMA8, BMS_ADDR_NONE, 1'b0, 1'b0);
         {BMS_VAR_D, 4'h2}: return mk(BMS_SRC_SPI2_MEM, BMS_ADDR_NONE, 1'b0, 1'b1);
         {BMS_VAR_D, 4'h3}: return mk(BMS_SRC_SPI2_HOST, BMS_ADDR_NONE, 1'b0, 1'b0);
         {BMS_VAR_D, 4'h4}: return mk(BMS_SRC_SPI_MEM, BMS_ADDR_NONE, 1'b0, 1'b1);
         {BMS_VAR_D, 4'h7}: return mk(BMS_SRC_INT_ROM, BMS_ADDR_FLASH, 1'b1, 1'b1);
         default: ;
      endcase
      return mk(BMS_SRC_RESERVED, BMS_ADDR_NONE, 1'b0, 1'b0);
   endfunction

   // -------------------------------------------------------------
   // shared tasks
   // -------------------------------------------------------------
   task automatic check(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // second reset in mid-run each time, then capture walk
   task automatic boot(input logic [3:0] code);
      @(posedge mclk) #1;
      rstn = 1'b0;
      wiggle = 1'b0;
      strap_code = code;
      repeat (2) @(posedge mclk);
      #1 rstn = 1'b1;
      @(posedge mclk) #1;
      for (int i = 0; i < 6; i++) begin
         check(vld[i] === 1'b0, "valid early");
         check(scr[i] === ((CFG_VAR[i] == BMS_VAR_C) ? code : {1'b0, code[2:0]}),
               "config view");
      end
      @(posedge mclk) #1;
   endtask

   task automatic compare(input logic [3:0] code);
      bms_decode_t e;
      bms_decode_t g;
      for (int i = 0; i < 6; i++) begin
         e = exp_dec(i, code);
         g = sel[i];
         check(vld[i] === 1'b1, "valid");
         check(fa[i] === BMS_ROM_ENTRY, "rom entry");
         check(g.src === e.src && g.idle === e.idle && g.reserved === e.reserved,
               "source");
         check(g.start_addr === e.start_addr && g.addr_valid === e.addr_valid,
               "start address");
         check(g.master === e.master, "master flag");
         check(g.nand_prefetch === e.nand_prefetch && g.otp_word32 === e.otp_word32,
               "stream flags");
      end
   endtask

   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic t_decode_table();
      for (int c = 0; c < 16; c++) begin
         boot(c[3:0]);
         compare(c[3:0]);
      end
      $display("test decode_table done");
   endtask

   task automatic t_hold_after_capture();
      boot(4'hb);
      wiggle = 1'b1;
      repeat (20) @(posedge mclk);
      #1;
      compare(4'hb);
      for (int i = 0; i < 6; i++) begin
         check(scr[i] === ((CFG_VAR[i] == BMS_VAR_C) ? 4'hb : 4'h3), "view held");
      end
      wiggle = 1'b0;
      $display("test hold_after_capture done");
   endtask

   task automatic t_far_side();
      @(posedge mclk) #1;
      hdma_pay = 16'h000d;
      @(posedge mclk) #1;
      check(hdma_len === 16'h0010, "host dma block not padded");
      check(otp_off === 12'h400, "otp hex offset");
      $display("test far_side done");
   endtask

   initial begin
      repeat (8) @(posedge mclk);
      #1 rstn = 1'b1;
      t_decode_table();
      t_hold_after_capture();
      t_far_side();
      end_sim();
   end

   initial begin
      #20000;
      error_cnt++;
      end_sim();
   end
endmodule // tb_bms_boot_mode_selector
`default_nettype wire
